// ==== pabr_regs.v ====
// management-link slave holding identifier, advertisement, partner ability and expansion registers
`timescale 1ns/100ps
`include "pabr_consts.vh"

// What this block does
// - identifier word: organisation bits 15:10, model 9:4, revision 3:0, read-only
// - advertisement bit 15 next-page request, writable, resets to zero
// - advertisement bit 13 remote fault, writable, resets to zero
// - advertisement bits 14, 12:11 and 9 read zero and ignore writes
// - advertisement bit 10 pause, writable, resets to zero
// - advertisement bits 8..5 speed and duplex abilities, writable, reset zero
// - advertisement selector bits 4:0 fixed read-only at 00001
// - partner ability register loads partner base page on every base page strobe, whatever negotiation complete shows
// - partner register fields next page, ack, fault, ability, selector, reset zero
// - only base pages are captured; next-page words are not stored
// - expansion bit 4 latches parallel detection fault; bits 15:5 read zero
// - expansion bit 3 shows partner next-page ability, reset zero
// - expansion bit 2 shows local next-page ability, reads one
// - expansion bit 1 latches new page received
// - expansion bit 0 shows partner auto-negotiation ability, reset zero
// - all registers reached over serial management clock and data link
module pabr_regs #(
  parameter [4:0] PHY_ADDR = 5'h01,
  parameter [5:0] ORG_CODE = 6'h2A,
  parameter [5:0] MODEL_NUM = 6'h15,
  parameter [3:0] REV_NUM = 4'h3
) (
  input wire mclk,
  input wire sys_rst,
  input wire mgmt_clk,
  input wire mgmt_data_in,
  output reg mgmt_data_out,
  output reg mgmt_data_oe,
  input wire an_complete,
  input wire page_rx_stb,
  input wire page_is_base,
  input wire [15:0] page_word,
  input wire par_det_fault,
  input wire lp_np_able,
  input wire lp_an_able,
  output reg [15:0] adv_word,
  output reg [15:0] lpa_word
);
  // identifier values above are arbitrary
  localparam ST_PRE = 5'h01;
  localparam ST_HDR = 5'h02;
  localparam ST_TA = 5'h04;
  localparam ST_RD = 5'h08;
  localparam ST_WR = 5'h10;

  // ----------------------------------------
  // input synchronisers
  // ----------------------------------------
  reg mdc_s1_r;
  reg mdc_s2_r;
  reg mdc_d_r;
  reg mdi_s1_r;
  reg mdi_s2_r;
  reg an_s1_r;
  reg an_s2_r;
  reg an_d_r;
  reg pdf_s1_r;
  reg pdf_s2_r;
  reg lpnp_s1_r;
  reg lpnp_s2_r;
  reg lpan_s1_r;
  reg lpan_s2_r;
  // logic reads only the second stage of each pair
  always @(posedge mclk) begin
    if (sys_rst) begin
      mdc_s1_r <= 1'b0;
      mdc_s2_r <= 1'b0;
      mdc_d_r <= 1'b0;
      mdi_s1_r <= 1'b1;
      mdi_s2_r <= 1'b1;
      an_s1_r <= 1'b0;
      an_s2_r <= 1'b0;
      an_d_r <= 1'b0;
      pdf_s1_r <= 1'b0;
      pdf_s2_r <= 1'b0;
      lpnp_s1_r <= 1'b0;
      lpnp_s2_r <= 1'b0;
      lpan_s1_r <= 1'b0;
      lpan_s2_r <= 1'b0;
    end else begin
      mdc_s1_r <= mgmt_clk;
      mdc_s2_r <= mdc_s1_r;
      mdc_d_r <= mdc_s2_r;
      mdi_s1_r <= mgmt_data_in;
      mdi_s2_r <= mdi_s1_r;
      an_s1_r <= an_complete;
      an_s2_r <= an_s1_r;
      an_d_r <= an_s2_r;
      pdf_s1_r <= par_det_fault;
      pdf_s2_r <= pdf_s1_r;
      lpnp_s1_r <= lp_np_able;
      lpnp_s2_r <= lpnp_s1_r;
      lpan_s1_r <= lp_an_able;
      lpan_s2_r <= lpan_s1_r;
    end
  end

  wire mdc_rise = mdc_s2_r & ~mdc_d_r;
  wire mdc_fall = ~mdc_s2_r & mdc_d_r;
  wire an_rise = an_s2_r & ~an_d_r;

  // ----------------------------------------
  // serial frame engine
  // ----------------------------------------
  reg [4:0] state_r;
  reg [5:0] cnt_r;
  reg [13:0] hdr_r;
  reg [15:0] sh_r;
  reg rd_clr_r;
  reg wr_stb_r;
  reg [4:0] wr_reg_r;
  reg [15:0] wr_data_r;
  reg [15:0] exp_word_r;
  reg pdf_r;
  reg pr_r;
  reg npa_r;
  reg lpnpa_r;
  reg lpana_r;

  wire [15:0] id_word = {ORG_CODE, MODEL_NUM, REV_NUM};
  // header fields as shifted in, start bits first
  wire [1:0] hdr_st = hdr_r[`PABR_HDR_ST];
  wire [1:0] hdr_op = hdr_r[`PABR_HDR_OP];
  wire [4:0] hdr_phy = hdr_r[`PABR_HDR_PHY];
  wire [4:0] hdr_reg = hdr_r[`PABR_HDR_REG];
  wire hdr_ok = (hdr_st == `PABR_ST) && (hdr_phy == PHY_ADDR);

  // ----------------------------------------
  // register read view
  // ----------------------------------------
  // unmapped addresses read as zero
  function [15:0] rd_mux;
    input [4:0] ra;
    begin
      case (ra)
        `PABR_REG_ID_LOW: rd_mux = id_word;
        `PABR_REG_ADV: rd_mux = adv_word;
        `PABR_REG_LPA: rd_mux = lpa_word;
        `PABR_REG_EXP: rd_mux = exp_word_r;
        default: rd_mux = 16'h0000;
      endcase
    end
  endfunction

  // expansion view: live levels plus two sticky flags
  always @* begin
    exp_word_r = 16'h0000;
    exp_word_r[`PABR_EXP_PDF] = pdf_r;
    exp_word_r[`PABR_EXP_LPNPA] = lpnpa_r;
    exp_word_r[`PABR_EXP_NPA] = npa_r;
    exp_word_r[`PABR_EXP_PR] = pr_r;
    exp_word_r[`PABR_EXP_LPANA] = lpana_r;
  end

  always @(posedge mclk) begin
    if (sys_rst) begin
      state_r <= ST_PRE;
      cnt_r <= 6'h00;
      hdr_r <= 14'h0000;
      sh_r <= 16'h0000;
      mgmt_data_out <= 1'b1;
      mgmt_data_oe <= 1'b0;
      rd_clr_r <= 1'b0;
      wr_stb_r <= 1'b0;
      wr_reg_r <= 5'h00;
      wr_data_r <= 16'h0000;
    end else begin
      rd_clr_r <= 1'b0;
      wr_stb_r <= 1'b0;
      case (state_r)
        ST_PRE: begin
          mgmt_data_oe <= 1'b0;
          if (mdc_rise) begin
            // extra preamble ones are tolerated, count saturates
            if (mdi_s2_r) begin
              if (cnt_r != `PABR_PRE_LEN)
                cnt_r <= cnt_r + 6'h01;
            end else if (cnt_r == `PABR_PRE_LEN) begin
              hdr_r <= 14'h0000;
              cnt_r <= 6'h01;
              state_r <= ST_HDR;
            end else begin
              cnt_r <= 6'h00;
            end
          end
        end
        ST_HDR: begin
          if (mdc_rise) begin
            hdr_r <= {hdr_r[12:0], mdi_s2_r};
            cnt_r <= cnt_r + 6'h01;
            if (cnt_r == `PABR_HDR_LEN - 6'h01) begin
              cnt_r <= 6'h00;
              state_r <= ST_TA;
            end
          end
        end
        ST_TA: begin
          if (!hdr_ok) begin
            cnt_r <= 6'h00;
            state_r <= ST_PRE;
          end else if (hdr_op == `PABR_OP_RD) begin
            if (mdc_fall) begin
              cnt_r <= cnt_r + 6'h01;
              // first turnaround bit stays released for the pull-up
              if (cnt_r == `PABR_TA_LEN - 6'h01) begin
                mgmt_data_oe <= 1'b1;
                mgmt_data_out <= 1'b0;
                sh_r <= rd_mux(hdr_reg);
                if (hdr_reg == `PABR_REG_EXP)
                  rd_clr_r <= 1'b1;
              end else if (cnt_r == `PABR_TA_LEN) begin
                mgmt_data_out <= sh_r[15];
                sh_r <= {sh_r[14:0], 1'b0};
                cnt_r <= 6'h01;
                state_r <= ST_RD;
              end
            end
          end else if (hdr_op == `PABR_OP_WR) begin
            if (mdc_rise) begin
              cnt_r <= cnt_r + 6'h01;
              if (cnt_r == `PABR_TA_LEN - 6'h01) begin
                cnt_r <= 6'h00;
                state_r <= ST_WR;
              end
            end
          end else begin
            cnt_r <= 6'h00;
            state_r <= ST_PRE;
          end
        end
        ST_RD: begin
          if (mdc_fall) begin
            if (cnt_r == `PABR_DATA_LEN) begin
              mgmt_data_oe <= 1'b0;
              mgmt_data_out <= 1'b1;
              cnt_r <= 6'h00;
              state_r <= ST_PRE;
            end else begin
              mgmt_data_out <= sh_r[15];
              sh_r <= {sh_r[14:0], 1'b0};
              cnt_r <= cnt_r + 6'h01;
            end
          end
        end
        ST_WR: begin
          if (mdc_rise) begin
            sh_r <= {sh_r[14:0], mdi_s2_r};
            cnt_r <= cnt_r + 6'h01;
            // write lands one cycle after the last data bit
            if (cnt_r == `PABR_DATA_LEN - 6'h01) begin
              wr_stb_r <= 1'b1;
              wr_reg_r <= hdr_reg;
              wr_data_r <= {sh_r[14:0], mdi_s2_r};
              cnt_r <= 6'h00;
              state_r <= ST_PRE;
            end
          end
        end
        default: begin
          cnt_r <= 6'h00;
          state_r <= ST_PRE;
        end
      endcase
    end
  end

  // ----------------------------------------
  // register storage
  // ----------------------------------------
  always @(posedge mclk) begin
    if (sys_rst) begin
      adv_word <= `PABR_ADV_RST | `PABR_SELECTOR;
      lpa_word <= `PABR_LPA_RST;
      pdf_r <= 1'b0;
      pr_r <= 1'b0;
      npa_r <= 1'b1;
      lpnpa_r <= 1'b0;
      lpana_r <= 1'b0;
    end else begin
      // only NP, RF, pause and four abilities take writes, selector fixed
      if (wr_stb_r && wr_reg_r == `PABR_REG_ADV)
        adv_word <= (wr_data_r & `PABR_ADV_WMASK) | `PABR_SELECTOR;
      // partner word kept for every base page, host checks completion
      if (page_rx_stb && page_is_base)
        lpa_word <= page_word;
      // set wins over clear on read
      pdf_r <= pdf_s2_r | (pdf_r & ~rd_clr_r);
      pr_r <= an_rise | (page_rx_stb) | (pr_r & ~rd_clr_r);
      npa_r <= 1'b1;
      lpnpa_r <= lpnp_s2_r;
      lpana_r <= lpan_s2_r;
    end
  end
endmodule

// ==== pabr_consts.vh ====
// constants for the transceiver auto-negotiation ability register bank
`ifndef PABR_CONSTS_VH
`define PABR_CONSTS_VH
// register addresses on the management link
`define PABR_REG_ID_LOW 5'h03
`define PABR_REG_ADV 5'h04
`define PABR_REG_LPA 5'h05
`define PABR_REG_EXP 5'h06
// management frame codes
`define PABR_ST 2'h1
`define PABR_OP_RD 2'h2
`define PABR_OP_WR 2'h1
`define PABR_TA_WR 2'h2
// frame layout in serial bit counts
`define PABR_PRE_LEN 6'h20
`define PABR_HDR_LEN 6'h0E
`define PABR_DATA_LEN 6'h10
`define PABR_TA_LEN 6'h02
// header field positions in the shifted header
`define PABR_HDR_ST 13:12
`define PABR_HDR_OP 11:10
`define PABR_HDR_PHY 9:5
`define PABR_HDR_REG 4:0
// advertisement field positions
`define PABR_ADV_NP 15
`define PABR_ADV_RF 13
`define PABR_ADV_PAUSE 10
`define PABR_ADV_TXFD 8
`define PABR_ADV_TXHD 7
`define PABR_ADV_TFD 6
`define PABR_ADV_THD 5
`define PABR_ADV_WMASK 16'hA5E0
`define PABR_SELECTOR 16'h0001
// expansion field positions
`define PABR_EXP_PDF 4
`define PABR_EXP_LPNPA 3
`define PABR_EXP_NPA 2
`define PABR_EXP_PR 1
`define PABR_EXP_LPANA 0
// reset values
`define PABR_ADV_RST 16'h0000
`define PABR_LPA_RST 16'h0000
`endif

// ==== pabr_host.sv ====
// host-side management link model
`timescale 1ns/100ps
module pabr_host (
  output logic mgmt_clk,
  output logic host_drv,
  input wire logic line,
  output logic [15:0] rd_data,
  output logic rd_stb
);
  logic [4:0] phy_addr = 5'h01;
  initial begin
    mgmt_clk = 1'b0;
    host_drv = 1'b1;
    rd_stb = 1'b0;
    rd_data = 16'h0000;
  end
  // one frame; clock stands low between frames, released data reads as pull-up
  task xfer(input logic [1:0] op, input logic [4:0] ra, input logic [15:0] wd);
    logic [63:0] v;
    v = {32'hFFFFFFFF, 2'h1, op, phy_addr, ra, 2'h2, wd};
    if (op == 2'h2) v[17:0] = 18'h3FFFF;
    for (int i = 63; i >= 0; i--) begin
      host_drv = v[i];
      #62.5 mgmt_clk = 1'b1;
      if (i < 16) rd_data[i] = line;
      #62.5 mgmt_clk = 1'b0;
    end
    host_drv = 1'b1;
    #250;
    if (op == 2'h2) rd_stb = 1'b1;
    #1 rd_stb = 1'b0;
  endtask
endmodule

// ==== pabr_chk.sv ====
// port assertions for the ability register bank
`timescale 1ns/100ps
module pabr_chk (
  input wire mclk,
  input wire sys_rst,
  input wire mgmt_clk,
  input wire mgmt_data_in,
  input wire mgmt_data_out,
  input wire mgmt_data_oe,
  input wire an_complete,
  input wire page_rx_stb,
  input wire page_is_base,
  input wire [15:0] page_word,
  input wire par_det_fault,
  input wire lp_np_able,
  input wire lp_an_able,
  input wire [15:0] adv_word,
  input wire [15:0] lpa_word
);
  default clocking @(posedge mclk); endclocking
  default disable iff (sys_rst);
  a_sel_fixed: assert property (adv_word[4:0] == 5'h01) else $error("selector");
  a_rsvd_zero: assert property ((adv_word & 16'h5A00) == 16'h0000) else $error("reserved");
  a_rst_vals: assert property ($fell(sys_rst) |-> adv_word == 16'h0001 && lpa_word == 16'h0000)
    else $error("reset values");
  a_lpa_base: assert property (page_rx_stb && page_is_base |=> lpa_word == $past(page_word))
    else $error("base capture");
  a_lpa_next: assert property (page_rx_stb && !page_is_base |=> $stable(lpa_word))
    else $error("next page stored");
  a_lpa_quiet: assert property (!page_rx_stb |=> $stable(lpa_word)) else $error("lpa moved");
  a_ta_zero: assert property ($rose(mgmt_data_oe) |-> !mgmt_data_out) else $error("turnaround");
  a_oe_span: assert property ($rose(mgmt_data_oe) |-> mgmt_data_oe[*8] ##[1:1000] !mgmt_data_oe)
    else $error("drive span");
  cover property ($rose(mgmt_data_oe));
  cover property (page_rx_stb && page_is_base);
  cover property ($changed(adv_word));
endmodule
bind pabr_regs pabr_chk pabr_chk_inst (.mclk, .sys_rst, .mgmt_clk, .mgmt_data_in, .mgmt_data_out,
  .mgmt_data_oe, .an_complete, .page_rx_stb, .page_is_base, .page_word, .par_det_fault, .lp_np_able,
  .lp_an_able, .adv_word, .lpa_word);

// ==== testbench.sv ====
// self-checking bench for the ability register bank
`timescale 1ns/100ps
`include "pabr_consts.vh"
module testbench;
  logic mclk, sys_rst, an_complete, page_rx_stb, page_is_base, par_det_fault, lp_np_able, lp_an_able;
  logic mgmt_clk, host_drv, rd_stb, mgmt_data_out, mgmt_data_oe;
  logic [15:0] page_word, rd_data, adv_word, lpa_word, r;
  wire line;
  int err_count = 0;
  int check_count = 0;
  int seed = 32'h1cc7;
  logic [15:0] exp_q[$];
  assign line = mgmt_data_oe ? mgmt_data_out : host_drv;
  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end
  pabr_regs pabr_regs_inst (.mclk, .sys_rst, .mgmt_clk, .mgmt_data_in(line), .mgmt_data_out, .mgmt_data_oe,
    .an_complete, .page_rx_stb, .page_is_base, .page_word, .par_det_fault, .lp_np_able, .lp_an_able,
    .adv_word, .lpa_word);
  pabr_host pabr_host_inst (.mgmt_clk, .host_drv, .line, .rd_data, .rd_stb);
  task check(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_count++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task end_sim;
    $display("checks=%0d errors=%0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task rd(input logic [4:0] ra, input logic [15:0] exp);
    exp_q.push_back(exp);
    pabr_host_inst.xfer(`PABR_OP_RD, ra, 16'h0000);
  endtask
  task page(input logic base, input logic [15:0] w);
    @(posedge mclk);
    page_rx_stb <= 1'b1;
    page_is_base <= base;
    page_word <= w;
    @(posedge mclk);
    page_rx_stb <= 1'b0;
  endtask
  always @(posedge rd_stb) check(rd_data, exp_q.pop_front());
  initial begin
    #500000;
    err_count++;
    end_sim;
  end
  initial begin
    sys_rst = 1'b1;
    an_complete = 1'b0;
    page_rx_stb = 1'b0;
    page_is_base = 1'b0;
    page_word = 16'h0000;
    par_det_fault = 1'b0;
    lp_np_able = 1'b0;
    lp_an_able = 1'b0;
    repeat (2) @(posedge mclk);
    sys_rst <= 1'b0;
    repeat (3) @(posedge mclk);
    rd(`PABR_REG_ID_LOW, 16'hA953);
    rd(`PABR_REG_ADV, 16'h0001);
    rd(`PABR_REG_LPA, 16'h0000);
    rd(`PABR_REG_EXP, 16'h0004);
    rd(5'h07, 16'h0000);
    $display("test reset values done");
    for (int k = 0; k < 4; k++) begin
      r = (k == 0) ? 16'hFFFF : 16'($random(seed));
      pabr_host_inst.xfer(`PABR_OP_WR, `PABR_REG_ADV, r);
      rd(`PABR_REG_ADV, (r & 16'hA5E0) | 16'h0001);
    end
    pabr_host_inst.phy_addr = 5'h02;
    pabr_host_inst.xfer(`PABR_OP_WR, `PABR_REG_ADV, ~r);
    pabr_host_inst.phy_addr = 5'h01;
    rd(`PABR_REG_ADV, (r & `PABR_ADV_WMASK) | `PABR_SELECTOR);
    pabr_host_inst.xfer(`PABR_OP_WR, `PABR_REG_ID_LOW, 16'h0000);
    pabr_host_inst.xfer(`PABR_OP_WR, `PABR_REG_EXP, 16'hFFFF);
    rd(`PABR_REG_ID_LOW, 16'hA953);
    $display("test advertisement done");
    r = 16'($random(seed));
    @(posedge mclk);
    lp_np_able <= 1'b1;
    lp_an_able <= 1'b1;
    par_det_fault <= 1'b1;
    an_complete <= 1'b1;
    page(1'b1, r);
    page(1'b0, ~r);
    pabr_host_inst.xfer(`PABR_OP_WR, `PABR_REG_LPA, 16'h0000);
    rd(`PABR_REG_LPA, r);
    rd(`PABR_REG_EXP, 16'h001F);
    @(posedge mclk);
    par_det_fault <= 1'b0;
    rd(`PABR_REG_EXP, 16'h001D);
    rd(`PABR_REG_EXP, 16'h000D);
    @(posedge mclk);
    lp_np_able <= 1'b0;
    lp_an_able <= 1'b0;
    rd(`PABR_REG_EXP, 16'h0004);
    $display("test partner pages done");
    end_sim;
  end
endmodule
